// File: rtl/lbip_pkg.sv
package lbip_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PERIOD_MS = 8;
  localparam int unsigned STEPS = 16;
  // One modulation step is a sixteenth of the period: 12500 cycles at 25 MHz.
  localparam int unsigned STEP_CYCLES = (CLK_HZ / 1000) * PERIOD_MS / STEPS;
  localparam int unsigned STEP_CNT_W = 14;

  // ****************************************************************
  // Register pointer and layout
  // ****************************************************************
  localparam logic [3:0] SELECT0_IDX = 4'h0;
  localparam logic [3:0] SELECT1_IDX = 4'h1;
  localparam logic [3:0] SELECT2_IDX = 4'h2;
  localparam logic [3:0] FADE_ON_IDX = 4'h3;
  localparam logic [3:0] FULLY_ON_IDX = 4'h4;
  localparam logic [3:0] FADE_OFF_IDX = 4'h5;
  localparam logic [3:0] FULLY_OFF1_IDX = 4'h6;
  localparam logic [3:0] FULLY_OFF2_IDX = 4'h7;
  localparam logic [3:0] PEAK_IDX = 4'(FULLY_OFF2_IDX + 4'h1);
  localparam int unsigned AUTO_INC_BIT = 4;
  localparam logic [3:0] PTR_RESET = 4'h0;
  localparam logic AUTO_INC_RESET = 1'b0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] NIBBLE_RESET = 4'hF;
  localparam logic [7:0] PEAK_RESET = {NIBBLE_RESET, NIBBLE_RESET};
  localparam logic [3:0] PHASE_RESET = 4'h0;
  localparam int unsigned LED_COUNT = 7;

  // Picks the intensity nibble of one bank: 0 is the low nibble, 1 the high.
  function automatic logic [3:0] lbip_nibble(input logic [7:0] value, input logic bank);
    return bank ? value[7:4] : value[3:0];
  endfunction : lbip_nibble

endpackage : lbip_pkg

// File: rtl/lbip_pwm_if.sv
interface lbip_pwm_if;
  timeunit 1ns;
  timeprecision 1ps;
  import lbip_pkg::*;

  logic [7:0] peak;
  logic [1:0] bank_low;
  logic [3:0] phase;

  modport ctrl (output peak, input bank_low, input phase);
  modport modu (input peak, output bank_low, output phase);

endinterface : lbip_pwm_if

// File: rtl/lbip_modulator.sv
module lbip_modulator
  import lbip_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  lbip_pwm_if.modu pwm
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Step divider and phase
  // ****************************************************************
  logic [STEP_CNT_W-1:0] step_cnt;
  logic [STEP_CNT_W-1:0] next_step_cnt;
  logic [3:0] phase;
  logic [3:0] next_phase;
  logic [1:0] bank_low;
  logic [1:0] next_bank_low;
  logic step_en;

  always_comb begin
    step_en = (step_cnt == STEP_CNT_W'(STEP_LEN - 1));
    next_step_cnt = step_en ? '0 : STEP_CNT_W'(step_cnt + 1'b1);
    // Sixteen steps make one 8 ms period.
    next_phase = step_en ? 4'(phase + 4'h1) : phase; // see R3
    for (int b = 0; b < 2; b++) begin
      // Low for nibble plus one steps out of sixteen; 15 keeps it low all period.
      next_bank_low[b] = (next_phase <= lbip_nibble(pwm.peak, b[0])); // see R11
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step_cnt <= '0;
      phase <= PHASE_RESET;
      bank_low <= 2'h3;
    end else begin
      step_cnt <= next_step_cnt;
      phase <= next_phase;
      bank_low <= next_bank_low;
    end
  end

  assign pwm.bank_low = bank_low;
  assign pwm.phase = phase;

endmodule : lbip_modulator

// File: rtl/lbip_top.sv
// How it works
// R1: High nibble second bank, low nibble first.
// R2: Both nibbles reset to 15, full brightness.
// R3: Brightness is duty cycle over 8 ms.
// R4: Nibble 0111 gives half brightness.
// R5: Nibble 1111 keeps output low whole period.
// R6: Brightness fraction equals output low fraction.
// R7: Intensity register follows second fully-off register.
// R8: Host writes intensity register to change brightness.
// R9: Second-bank outputs use second bank intensity.
// R10: Auto-increment advances pointer low four bits.
// R11: Low fraction is nibble plus one over sixteen.
module lbip_top
  import lbip_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic [LED_COUNT-1:0] pwm_enable,
  input wire logic [LED_COUNT-1:0] second_bank_sel,
  output logic [LED_COUNT-1:0] led_out,
  output logic [LED_COUNT-1:0] led_oe_n,
  output logic [7:0] bank_peak_brightness,
  output logic [3:0] reg_pointer,
  output logic auto_increment,
  output logic [3:0] pwm_phase
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Register pointer and intensity register
  // ****************************************************************
  logic [7:0] peak;
  logic [7:0] next_peak;
  logic [3:0] pointer;
  logic [3:0] next_pointer;
  logic auto_inc;
  logic next_auto_inc;

  always_comb begin
    next_peak = peak;
    next_pointer = pointer;
    next_auto_inc = auto_inc;
    if (cmd_valid) begin
      next_pointer = cmd_byte[3:0];
      next_auto_inc = cmd_byte[AUTO_INC_BIT];
    end else if (data_valid) begin
      // The intensity register sits right after the second fully-off register.
      if (pointer == PEAK_IDX) begin // see R7
        next_peak = data_byte; // see R1
      end
      if (auto_inc) begin
        next_pointer = 4'(pointer + 4'h1); // see R10
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      peak <= PEAK_RESET; // see R2
      pointer <= PTR_RESET;
      auto_inc <= AUTO_INC_RESET;
    end else begin
      peak <= next_peak;
      pointer <= next_pointer;
      auto_inc <= next_auto_inc;
    end
  end

  // ****************************************************************
  // Modulator
  // ****************************************************************
  lbip_pwm_if pwm ();

  assign pwm.peak = peak;

  lbip_modulator #(
    .STEP_LEN(STEP_LEN)
  ) u_modulator (
    .clock(clock),
    .rstn(rstn),
    .pwm(pwm)
  );

  // ****************************************************************
  // Open-drain outputs
  // ****************************************************************
  logic [LED_COUNT-1:0] drive_n;
  logic [LED_COUNT-1:0] next_drive_n;

  always_comb begin
    for (int i = 0; i < LED_COUNT; i++) begin
      // With its pwm_enable bit set, the pin is pulled low for the bank's low fraction and released otherwise.
      next_drive_n[i] = ~(pwm_enable[i] & pwm.bank_low[second_bank_sel[i]]); // see R9, R6, R4, R5
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drive_n <= '1;
    end else begin
      drive_n <= next_drive_n;
    end
  end

  assign led_out = '0;
  assign led_oe_n = drive_n;
  assign bank_peak_brightness = peak;
  assign reg_pointer = pointer;
  assign auto_increment = auto_inc;
  assign pwm_phase = pwm.phase;

endmodule : lbip_top

// File: sim/lbip_top_sva.sv
module lbip_top_sva
  import lbip_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  input wire logic [LED_COUNT-1:0] pwm_enable,
  input wire logic [LED_COUNT-1:0] second_bank_sel,
  input wire logic [LED_COUNT-1:0] led_out,
  input wire logic [LED_COUNT-1:0] led_oe_n,
  input wire logic [7:0] bank_peak_brightness,
  input wire logic [3:0] reg_pointer,
  input wire logic auto_increment,
  input wire logic [3:0] pwm_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic wr;
  assign wr = data_valid && !cmd_valid;
  sequence quiet_s;
    $stable(bank_peak_brightness) && $stable(pwm_enable) && $stable(second_bank_sel);
  endsequence
  property duty_p(int i);
    quiet_s ##1 quiet_s |-> led_oe_n[i] == !(pwm_enable[i] && $past(pwm_phase) <=
      (second_bank_sel[i] ? bank_peak_brightness[7:4] : bank_peak_brightness[3:0]));
  endproperty
  peak_store_a: assert property (wr && reg_pointer == PEAK_IDX |=>
    bank_peak_brightness == $past(data_byte)) else $error("peak not stored");
  peak_hold_a: assert property (!(wr && reg_pointer == PEAK_IDX) |=>
    $stable(bank_peak_brightness)) else $error("peak changed unasked");
  ptr_load_a: assert property (cmd_valid |=> reg_pointer == $past(cmd_byte[3:0]) &&
    auto_increment == $past(cmd_byte[4])) else $error("pointer not loaded");
  ptr_step_a: assert property (wr && auto_increment |=>
    reg_pointer == 4'($past(reg_pointer) + 4'h1)) else $error("pointer not advanced");
  phase_step_a: assert property ($changed(pwm_phase) |->
    pwm_phase == 4'($past(pwm_phase) + 4'h1)) else $error("phase skipped");
  // The repetition count matches the shortened step of four cycles.
  step_len_a: assert property ($changed(pwm_phase) |=> $stable(pwm_phase) [*3])
    else $error("step length wrong");
  first_duty_a: assert property (duty_p(0)) else $error("led0 duty wrong");
  second_duty_a: assert property (duty_p(1)) else $error("led1 duty wrong");
  pin_low_a: assert property (led_out == '0) else $error("pin data not low");
endmodule : lbip_top_sva

// File: sim/lbip_host_model.sv
module lbip_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic data_valid,
  output logic [7:0] data_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cmd_valid, data_valid, cmd_byte, data_byte} = '0;
  end
  // Released bytes show the inverse so stale data never looks valid.
  task automatic put(input logic is_cmd, input logic [7:0] b);
    @(posedge clock);
    #1;
    if (is_cmd) begin
      {cmd_valid, cmd_byte} = {1'b1, b};
    end else begin
      {data_valid, data_byte} = {1'b1, b};
    end
    @(posedge clock);
    #1;
    {cmd_valid, data_valid, cmd_byte, data_byte} = {2'b00, ~b, ~b};
  endtask : put
endmodule : lbip_host_model

// File: sim/led_bank_intensity_pwm_tb.sv
module led_bank_intensity_pwm_tb
  import lbip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STEP_LEN = 4;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, data_valid, auto_increment;
  logic [7:0] cmd_byte, data_byte, bank_peak_brightness;
  logic [LED_COUNT-1:0] pwm_enable = 7'h7F, second_bank_sel = 7'h02, led_out, led_oe_n;
  logic [3:0] reg_pointer, pwm_phase;
  int num_errors = 0;
  int total_checks = 0;
  always #20 clock = ~clock;
  lbip_host_model host (.clock(clock), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .data_valid(data_valid), .data_byte(data_byte));
  lbip_top #(.STEP_LEN(STEP_LEN)) dut (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .data_valid(data_valid), .data_byte(data_byte),
    .pwm_enable(pwm_enable), .second_bank_sel(second_bank_sel), .led_out(led_out),
    .led_oe_n(led_oe_n), .bank_peak_brightness(bank_peak_brightness),
    .reg_pointer(reg_pointer), .auto_increment(auto_increment), .pwm_phase(pwm_phase));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic duty(input int i, input logic [7:0] exp);
    logic [7:0] n = 8'h00;
    repeat (3) @(posedge clock);
    repeat (16 * STEP_LEN) begin
      @(posedge clock);
      #2;
      if (led_oe_n[i] === 1'b0) n++;
    end
    check("low cycles", n, exp);
  endtask : duty
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clock);
    #1 rstn = 1'b1;
    check("peak", bank_peak_brightness, 8'hFF);
    check("pointer", {3'h0, auto_increment, reg_pointer}, 8'h00);
    check("pin data", {1'b0, led_out}, 8'h00);
    duty(0, 8'h40);
    $display("test reset done");
    host.put(1, 8'h16);
    host.put(0, 8'h11);
    host.put(0, 8'h22);
    host.put(0, 8'h73);
    check("peak", bank_peak_brightness, 8'h73);
    check("pointer", {4'h0, reg_pointer}, 8'h09);
    duty(1, 8'h20);
    duty(0, 8'h10);
    $display("test auto write done");
    host.put(1, 8'h1F);
    host.put(0, 8'hAA);
    check("pointer", {4'h0, reg_pointer}, 8'h00);
    check("peak", bank_peak_brightness, 8'h73);
    host.put(1, 8'h08);
    host.put(0, 8'hF0);
    check("pointer", {4'h0, reg_pointer}, 8'h08);
    duty(1, 8'h40);
    duty(0, 8'h04);
    @(posedge clock);
    #1 pwm_enable = 7'h00;
    duty(1, 8'h00);
    $display("test wrap done");
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    check("peak", bank_peak_brightness, 8'hFF);
    $display("test second reset done");
    final_report();
  end
endmodule : led_bank_intensity_pwm_tb
bind lbip_top lbip_top_sva #(.STEP_LEN(STEP_LEN)) u_sva (.clock(clock), .rstn(rstn),
  .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .data_valid(data_valid),
  .data_byte(data_byte), .pwm_enable(pwm_enable), .second_bank_sel(second_bank_sel),
  .led_out(led_out), .led_oe_n(led_oe_n), .bank_peak_brightness(bank_peak_brightness),
  .reg_pointer(reg_pointer), .auto_increment(auto_increment), .pwm_phase(pwm_phase));
